//--- css_pkg.sv
/*
  Shared constants, field layouts and types for the codec serial slot and status block.
  Assumes a 16-bit register port on the module clock and a codec that owns the serial clock and frame sync.
*/
package css_pkg;

  // Serial word and frame geometry
  localparam int DATA_W    = 16;
  localparam int SLOT_W    = 4;
  localparam int SLOTS     = 16;
  localparam int DEPTH_MAX = 4;
  localparam int PTR_W     = 2;
  localparam int DIV_W     = 12;
  localparam int ADDR_W    = 4;
  localparam int IRQ_W     = 4;

  // Register index map
  localparam logic [ADDR_W-1:0] ADDR_CLKCFG   = 4'h0;
  localparam logic [ADDR_W-1:0] ADDR_STATUS   = 4'h1;
  localparam logic [ADDR_W-1:0] ADDR_RXEN     = 4'h2;
  localparam logic [ADDR_W-1:0] ADDR_TXEN     = 4'h3;
  localparam logic [ADDR_W-1:0] ADDR_CTRL     = 4'h4;
  localparam logic [ADDR_W-1:0] ADDR_TXDATA   = 4'h5;
  localparam logic [ADDR_W-1:0] ADDR_RXDATA   = 4'h6;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_STAT = 4'h7;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_MASK = 4'h8;

  // Reset values
  localparam logic [DATA_W-1:0] RST_WORD = 16'h0000;
  localparam logic [DIV_W-1:0]  RST_DIV  = 12'h000;
  localparam logic [IRQ_W-1:0]  RST_IRQ  = 4'h0;

  // Interrupt status and mask bit positions
  localparam int IRQ_RXFULL  = 0;
  localparam int IRQ_TXEMPTY = 1;
  localparam int IRQ_ROV     = 2;
  localparam int IRQ_TRANSMIT_UNDERFLOW_FLAG    = 3;

  // Status flags, packed so that they land on status bits 3 down to 0
  typedef struct packed {
    logic receive_overflow_flag;
    logic receive_full_flag;
    logic transmit_underflow_flag;
    logic transmit_empty_flag;
  } css_flags_t;

  // Control register layout, bits 7 down to 0
  typedef struct packed {
    logic             underflow_mode;
    logic             idle_output_mode;
    logic [PTR_W-1:0] buffer_depth_setting;
    logic [SLOT_W-1:0] frame_length_words;
  } css_ctrl_t;

  localparam css_ctrl_t RST_CTRL = 8'h00;

  // Link framing state
  typedef enum logic [1:0] {
    CSS_WAIT = 2'b01,
    CSS_RUN  = 2'b10
  } css_state_t;

endpackage

//--- css_sync2.sv
/*
  Two-flop synchroniser for a group of independent level inputs.
  Assumes each bit is a slow level relative to the module clock; no bus coherence is given.
*/
`timescale 1ns/1ps
module css_sync2 #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         i_clk,
  input  wire logic         i_srst,
  // Data
  input  wire logic [W-1:0] i_async,
  output logic      [W-1:0] o_sync
);

  // A zero-width group has nothing to carry across
  if (W < 1) begin : g_bad_w
    $error("css_sync2: width must be at least 1");
  end

  logic [W-1:0] meta;

  // First stage feeds only the second stage
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      meta   <= '0;
      o_sync <= '0;
    end else begin
      meta   <= i_async;
      o_sync <= meta;
    end
  end

endmodule

//--- css_bitclk_div.sv
/*
  Bit clock generator: divides the module clock by a ratio set from a 12-bit value.
  Assumes the value may change at any time; a change takes effect in the half period already running.
*/
`timescale 1ns/1ps
module css_bitclk_div
  import css_pkg::*;
#(
  parameter int W = DIV_W
) (
  // Clock and reset
  input  wire logic         i_clk,
  input  wire logic         i_srst,
  // Ratio and generated clock
  input  wire logic [W-1:0] i_div,
  output logic              o_bclk
);

  // The half-period counter needs at least one bit
  if (W < 1) begin : g_bad_w
    $error("css_bitclk_div: width must be at least 1");
  end

  logic [W-1:0] cnt;

  // Each half period lasts the divider value plus one module clocks
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      cnt    <= '0;
      o_bclk <= 1'b0;
    end else if (cnt >= i_div) begin
      cnt    <= '0;
      o_bclk <= ~o_bclk;
    end else begin
      cnt <= cnt + 1'b1;
    end
  end

endmodule

//--- css_top.sv
/*
  Codec serial port slot engine: per-slot receive and transmit gating, status flags,
  small word buffers, interrupt status and mask, and bit clock generation.
  Assumes a register master on I_CLK and a codec driving serial clock and frame sync
  on pins; those pins are asynchronous and are synchronised here before use.
*/
`timescale 1ns/1ps
module css_top
  import css_pkg::*;
#(
  parameter int WORD_W = DATA_W,
  parameter int SLOT_N = SLOTS
) (
  // Clock and reset
  input  wire logic              I_CLK,
  input  wire logic              I_SRST,
  // Register port
  input  wire logic [ADDR_W-1:0] I_ADDR,
  input  wire logic [DATA_W-1:0] I_WDATA,
  input  wire logic              I_WR,
  input  wire logic              I_RD,
  output logic      [DATA_W-1:0] O_RDATA,
  // Codec link
  input  wire logic              I_SCK,
  input  wire logic              I_FS,
  input  wire logic              I_SDI,
  output logic                   O_SDO,
  output logic                   O_SDO_OE,
  output logic                   O_BCLK,
  // Interrupt
  output logic                   O_IRQ
);

  // The slot counter and buffers are sized for exactly these values
  if (WORD_W != DATA_W || SLOT_N != SLOTS) begin : g_bad_param
    $error("css_top: only 16-bit words and 16 slots are supported");
  end

  // Software visible configuration
  logic [DIV_W-1:0]  bit_clock_divider_value;
  logic [SLOTS-1:0]  receive_slot_enable;
  logic [SLOTS-1:0]  transmit_slot_enable;
  css_ctrl_t         ctrl;
  css_flags_t        flags;
  logic [IRQ_W-1:0]  irq_stat;
  logic [IRQ_W-1:0]  irq_mask;
  logic [IRQ_W-1:0]  irq_event;

  // Synchronised link inputs and their history
  logic [2:0]        link_sync;
  logic              sck_s;
  logic              fs_s;
  logic              serial_data_in;
  logic              sck_d;
  logic              sck_rise;
  logic              sck_fall;

  // Link engine state
  css_state_t        state;
  logic [SLOT_W-1:0] slot;
  logic [SLOT_W-1:0] bit_idx;
  logic              load_pending;
  logic [DATA_W-1:0] rx_shift;
  logic [DATA_W-1:0] tx_shift;
  logic [DATA_W-1:0] rx_word;
  logic              word_end;
  logic              rx_take;
  logic              tx_load;
  logic              tx_take;

  // Word buffers: receive filled by the link, transmit filled by software
  logic [DATA_W-1:0] rx_mem [DEPTH_MAX];
  logic [DATA_W-1:0] tx_mem [DEPTH_MAX];
  logic [PTR_W-1:0]  rx_wr;
  logic [PTR_W-1:0]  rx_rd;
  logic [PTR_W-1:0]  tx_wr;
  logic [PTR_W-1:0]  tx_rd;
  logic [DATA_W-1:0] last_tx;
  logic [DATA_W-1:0] next_tx_word;

  // Register strobes
  logic              wr_txdata;
  logic              rd_rxdata;
  logic              rd_status;

  assign wr_txdata = I_WR && (I_ADDR == ADDR_TXDATA);
  assign rd_rxdata = I_RD && (I_ADDR == ADDR_RXDATA);
  assign rd_status = I_RD && (I_ADDR == ADDR_STATUS);

  // Pins cross into the module clock domain before any logic sees them
  css_sync2 #(
    .W (3)
  ) u_sync (
    .i_clk   (I_CLK),
    .i_srst  (I_SRST),
    .i_async ({I_SCK, I_FS, I_SDI}),
    .o_sync  (link_sync)
  );

  assign sck_s          = link_sync[2];
  assign fs_s           = link_sync[1];
  assign serial_data_in = link_sync[0];

  // Generated bit clock for a codec that takes its clock from us
  css_bitclk_div #(
    .W (DIV_W)
  ) u_div (
    .i_clk  (I_CLK),
    .i_srst (I_SRST),
    .i_div  (bit_clock_divider_value),
    .o_bclk (O_BCLK)
  );

  // Edge detection runs on the synchronised copy only
  always_ff @(posedge I_CLK) begin
    if (I_SRST) begin
      sck_d <= 1'b0;
    end else begin
      sck_d <= sck_s;
    end
  end

  assign sck_rise = sck_s && !sck_d;
  assign sck_fall = !sck_s && sck_d;

  // Word boundary decode on the sampling edge
  assign word_end = sck_rise && (state == CSS_RUN) && !fs_s && (bit_idx == SLOT_W'(DATA_W - 1));
  assign rx_word  = {rx_shift[DATA_W-2:0], serial_data_in};
  assign rx_take  = word_end && receive_slot_enable[slot];
  assign tx_load  = sck_fall && load_pending;
  assign tx_take  = tx_load && transmit_slot_enable[slot] && !flags.transmit_empty_flag;

  // Underflow source: last written word or zeros
  always_comb begin
    if (flags.transmit_empty_flag) begin
      next_tx_word = ctrl.underflow_mode ? last_tx : RST_WORD;
    end else begin
      next_tx_word = tx_mem[tx_rd];
    end
  end

  // Framing: frame sync restarts slot zero, each word but the last advances the slot
  always_ff @(posedge I_CLK) begin
    if (I_SRST) begin
      state        <= CSS_WAIT;
      slot         <= '0;
      bit_idx      <= '0;
      load_pending <= 1'b0;
    end else begin
      case (state)
        CSS_WAIT: begin
          if (sck_rise && fs_s) begin
            state        <= CSS_RUN;
            slot         <= '0;
            bit_idx      <= '0;
            load_pending <= 1'b1;
          end else if (tx_load) begin
            load_pending <= 1'b0;
          end
        end
        CSS_RUN: begin
          if (sck_rise && fs_s) begin
            slot         <= '0;
            bit_idx      <= '0;
            load_pending <= 1'b1;
          end else if (word_end) begin
            bit_idx <= '0;
            if (slot == ctrl.frame_length_words) begin
              // Last word of the frame: wait for the next sync
              state <= CSS_WAIT;
              slot  <= '0;
            end else begin
              slot         <= slot + 4'h1;
              load_pending <= 1'b1;
            end
          end else begin
            if (sck_rise) begin
              bit_idx <= bit_idx + 4'h1;
            end
            if (tx_load) begin
              load_pending <= 1'b0;
            end
          end
        end
        default: begin
          state <= CSS_WAIT;
        end
      endcase
    end
  end

  // Receive shifter, MSB first
  always_ff @(posedge I_CLK) begin
    if (I_SRST) begin
      rx_shift <= RST_WORD;
    end else if (sck_rise && (state == CSS_RUN) && !fs_s) begin
      rx_shift <= rx_word;
    end
  end

  // Receive buffer fill; a full buffer drops the word and flags overflow
  always_ff @(posedge I_CLK) begin
    if (I_SRST) begin
      rx_wr <= '0;
    end else if (rx_take && !flags.receive_full_flag) begin
      rx_mem[rx_wr] <= rx_word;
      if (rx_wr == ctrl.buffer_depth_setting) begin
        rx_wr <= '0;
      end else begin
        rx_wr <= rx_wr + 2'h1;
      end
    end
  end

  // Software drains the receive block word by word
  always_ff @(posedge I_CLK) begin
    if (I_SRST) begin
      rx_rd <= '0;
    end else if (rd_rxdata && flags.receive_full_flag) begin
      if (rx_rd == ctrl.buffer_depth_setting) begin
        rx_rd <= '0;
      end else begin
        rx_rd <= rx_rd + 2'h1;
      end
    end
  end

  // Software fills the transmit block; the last word is kept for underflow repeat
  always_ff @(posedge I_CLK) begin
    if (I_SRST) begin
      tx_wr   <= '0;
      last_tx <= RST_WORD;
    end else if (wr_txdata) begin
      tx_mem[tx_wr] <= I_WDATA;
      last_tx       <= I_WDATA;
      if (tx_wr == ctrl.buffer_depth_setting) begin
        tx_wr <= '0;
      end else begin
        tx_wr <= tx_wr + 2'h1;
      end
    end
  end

  // Link consumes transmit words in enabled slots
  always_ff @(posedge I_CLK) begin
    if (I_SRST) begin
      tx_rd <= '0;
    end else if (tx_take) begin
      if (tx_rd == ctrl.buffer_depth_setting) begin
        tx_rd <= '0;
      end else begin
        tx_rd <= tx_rd + 2'h1;
      end
    end
  end

  // Serial output: load at slot start, shift on each change edge
  always_ff @(posedge I_CLK) begin
    if (I_SRST) begin
      tx_shift <= RST_WORD;
      O_SDO    <= 1'b0;
      O_SDO_OE <= 1'b0;
    end else if (tx_load) begin
      if (transmit_slot_enable[slot]) begin
        tx_shift <= next_tx_word;
        O_SDO    <= next_tx_word[DATA_W-1];
        O_SDO_OE <= 1'b1;
      end else begin
        // Floating lets another device use this slot
        tx_shift <= RST_WORD;
        O_SDO    <= 1'b0;
        O_SDO_OE <= !ctrl.idle_output_mode;
      end
    end else if (sck_fall) begin
      tx_shift <= {tx_shift[DATA_W-2:0], 1'b0};
      O_SDO    <= tx_shift[DATA_W-2];
    end
  end

  // Status flags; a hardware set wins over a clear in the same cycle
  always_ff @(posedge I_CLK) begin
    if (I_SRST) begin
      flags <= '0;
    end else begin
      if (rx_take && flags.receive_full_flag) begin
        flags.receive_overflow_flag <= 1'b1;
      end else if (rd_status) begin
        flags.receive_overflow_flag <= 1'b0;
      end
      if (rx_take && !flags.receive_full_flag && (rx_wr == ctrl.buffer_depth_setting)) begin
        flags.receive_full_flag <= 1'b1;
      end else if (rd_rxdata && flags.receive_full_flag && (rx_rd == ctrl.buffer_depth_setting)) begin
        flags.receive_full_flag <= 1'b0;
      end
      if (tx_load && transmit_slot_enable[slot] && flags.transmit_empty_flag) begin
        flags.transmit_underflow_flag <= 1'b1;
      end else if (rd_status) begin
        flags.transmit_underflow_flag <= 1'b0;
      end
      if (tx_take && (tx_rd == ctrl.buffer_depth_setting)) begin
        flags.transmit_empty_flag <= 1'b1;
      end else if (wr_txdata && (tx_wr == ctrl.buffer_depth_setting)) begin
        flags.transmit_empty_flag <= 1'b0;
      end
    end
  end

  // Interrupt events, one pulse each
  assign irq_event[IRQ_RXFULL]  = rx_take && !flags.receive_full_flag && (rx_wr == ctrl.buffer_depth_setting);
  assign irq_event[IRQ_TXEMPTY] = tx_take && (tx_rd == ctrl.buffer_depth_setting);
  assign irq_event[IRQ_ROV]     = rx_take && flags.receive_full_flag;
  assign irq_event[IRQ_TRANSMIT_UNDERFLOW_FLAG]    = tx_load && transmit_slot_enable[slot] && flags.transmit_empty_flag;

  // Sticky interrupt bits, write one to clear, event wins
  for (genvar i = 0; i < IRQ_W; i++) begin : g_irq
    always_ff @(posedge I_CLK) begin
      if (I_SRST) begin
        irq_stat[i] <= 1'b0;
      end else if (irq_event[i]) begin
        irq_stat[i] <= 1'b1;
      end else if (I_WR && (I_ADDR == ADDR_IRQ_STAT) && I_WDATA[i]) begin
        irq_stat[i] <= 1'b0;
      end
    end
  end

  // Level interrupt, registered so it comes from a flop
  always_ff @(posedge I_CLK) begin
    if (I_SRST) begin
      O_IRQ <= 1'b0;
    end else begin
      O_IRQ <= |(irq_stat & irq_mask);
    end
  end

  // Register writes
  always_ff @(posedge I_CLK) begin
    if (I_SRST) begin
      bit_clock_divider_value <= RST_DIV;
      receive_slot_enable     <= RST_WORD;
      transmit_slot_enable    <= RST_WORD;
      ctrl                    <= RST_CTRL;
      irq_mask                <= RST_IRQ;
    end else if (I_WR) begin
      if (I_ADDR == ADDR_CLKCFG) begin
        bit_clock_divider_value <= I_WDATA[DIV_W-1:0];
      end else if (I_ADDR == ADDR_RXEN) begin
        receive_slot_enable <= I_WDATA;
      end else if (I_ADDR == ADDR_TXEN) begin
        transmit_slot_enable <= I_WDATA;
      end else if (I_ADDR == ADDR_CTRL) begin
        ctrl <= I_WDATA[$bits(css_ctrl_t)-1:0];
      end else if (I_ADDR == ADDR_IRQ_MASK) begin
        irq_mask <= I_WDATA[IRQ_W-1:0];
      end
    end
  end

  // Read data stands in the cycle after the strobe only
  always_ff @(posedge I_CLK) begin
    if (I_SRST) begin
      O_RDATA <= RST_WORD;
    end else if (!I_RD) begin
      O_RDATA <= RST_WORD;
    end else if (I_ADDR == ADDR_CLKCFG) begin
      O_RDATA <= {4'h0, bit_clock_divider_value};
    end else if (I_ADDR == ADDR_STATUS) begin
      O_RDATA <= {4'h0, slot, 4'h0, flags};
    end else if (I_ADDR == ADDR_RXEN) begin
      O_RDATA <= receive_slot_enable;
    end else if (I_ADDR == ADDR_TXEN) begin
      O_RDATA <= transmit_slot_enable;
    end else if (I_ADDR == ADDR_CTRL) begin
      O_RDATA <= {8'h00, ctrl};
    end else if (I_ADDR == ADDR_RXDATA) begin
      O_RDATA <= rx_mem[rx_rd];
    end else if (I_ADDR == ADDR_IRQ_STAT) begin
      O_RDATA <= {12'h000, irq_stat};
    end else if (I_ADDR == ADDR_IRQ_MASK) begin
      O_RDATA <= {12'h000, irq_mask};
    end else begin
      O_RDATA <= RST_WORD;
    end
  end

endmodule

//--- css_codec_model.sv
/*
  Behavioural codec on the far side of the serial link: makes serial clock, frame sync and data in,
  and captures what the block shifts out. Assumes one run_frame call at a time; the bench may make register accesses while it runs.
*/
`timescale 1ns/1ps
module css_codec_model
  import css_pkg::*;
(
  // Lines driven toward the block
  output logic      o_sck,
  output logic      o_fs,
  output logic      o_sdi,
  // Lines driven by the block
  input  wire logic i_sdo,
  input  wire logic i_sdo_oe
);
  logic [DATA_W-1:0] rx_word;
  logic              oe_last;

  // Clock stands low outside frames
  initial begin
    o_sck   = 1'b0;
    o_fs    = 1'b0;
    o_sdi   = 1'b0;
    rx_word = '0;
    oe_last = 1'b0;
  end

  // Sync on the first rise, then n words MSB first; slot k carries base plus k
  task automatic run_frame(input int n, input logic [DATA_W-1:0] base);
    logic [DATA_W-1:0] w;
    #7 o_fs = 1'b1;
    #100 o_sck = 1'b1;
    #100 o_sck = 1'b0;
    o_fs = 1'b0;
    for (int i = 0; i < n * DATA_W; i++) begin
      w = base + DATA_W'(i / DATA_W);
      o_sdi = w[DATA_W-1-(i % DATA_W)];
      #100 o_sck = 1'b1;
      // Late in the high phase, so the synchronised output has settled
      // A floating output is seen as the inverse of the last bit, never as a held value
      #90 rx_word = {rx_word[DATA_W-2:0], i_sdo_oe ? i_sdo : ~rx_word[0]};
      oe_last = i_sdo_oe;
      #10 o_sck = 1'b0;
    end
    // Released line shows the inverse of its last bit, never a stale value
    o_sdi = ~o_sdi;
  endtask
endmodule

//--- css_top_checker.sv
/*
  Port-level assertions for the codec serial slot block.
  Assumes it is bound to css_top and sees only its ports.
*/
`timescale 1ns/1ps
module css_top_checker
  import css_pkg::*;
#(
  parameter int WORD_W = DATA_W,
  parameter int SLOT_N = SLOTS
) (
  // Clock and reset
  input wire logic              I_CLK,
  input wire logic              I_SRST,
  // Register port
  input wire logic [ADDR_W-1:0] I_ADDR,
  input wire logic [DATA_W-1:0] I_WDATA,
  input wire logic              I_WR,
  input wire logic              I_RD,
  input wire logic [DATA_W-1:0] O_RDATA,
  // Link and interrupt
  input wire logic              I_SCK,
  input wire logic              I_FS,
  input wire logic              I_SDI,
  input wire logic              O_SDO,
  input wire logic              O_SDO_OE,
  input wire logic              O_BCLK,
  input wire logic              O_IRQ
);
  logic [DIV_W-1:0]  cfg_q;
  logic [DIV_W-1:0]  half_cnt;
  logic [1:0]        n_tog;
  logic [SLOT_W-1:0] flen_q;

  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (I_SRST);

  // Shadows of the written divider and frame length
  always_ff @(posedge I_CLK) begin
    if (I_SRST) begin
      cfg_q  <= RST_DIV;
      flen_q <= '0;
    end else if (I_WR && I_ADDR == ADDR_CLKCFG) begin
      cfg_q <= I_WDATA[DIV_W-1:0];
    end else if (I_WR && I_ADDR == ADDR_CTRL) begin
      flen_q <= I_WDATA[SLOT_W-1:0];
    end
  end

  // Half-period length; trusted only after two toggles at one setting
  always_ff @(posedge I_CLK) begin
    if (I_SRST) begin
      half_cnt <= '0;
    end else if ($changed(O_BCLK)) begin
      half_cnt <= '0;
    end else begin
      half_cnt <= half_cnt + 1'b1;
    end
  end

  // Toggles seen since the last divider write
  always_ff @(posedge I_CLK) begin
    if (I_SRST || (I_WR && I_ADDR == ADDR_CLKCFG)) begin
      n_tog <= 2'h0;
    end else if ($changed(O_BCLK) && n_tog != 2'h2) begin
      n_tog <= n_tog + 2'h1;
    end
  end

  AST_RD_IDLE: assert property (!$past(I_RD) |-> O_RDATA == 16'h0000)
    else $error("read data not zero outside a read answer");
  AST_CFG_UPPER: assert property ($past(I_RD) && $past(I_ADDR) <= ADDR_STATUS |-> O_RDATA[15:12] == 4'h0)
    else $error("upper bits of config or status not zero");
  AST_STAT_GAP: assert property ($past(I_RD) && $past(I_ADDR) == ADDR_STATUS |-> O_RDATA[7:4] == 4'h0)
    else $error("status bits 7 to 4 not zero");
  AST_CFG_RW: assert property (I_WR && I_ADDR == ADDR_CLKCFG ##1 I_RD && I_ADDR == ADDR_CLKCFG
    |=> O_RDATA == ($past(I_WDATA, 2) & 16'h0FFF)) else $error("divider value not read back");
  AST_SLOT_RANGE: assert property ($past(I_RD) && $past(I_ADDR) == ADDR_STATUS |-> O_RDATA[11:8] <= flen_q)
    else $error("slot number beyond frame length");
  AST_SDO_EDGE: assert property ($changed(O_SDO) |-> !$past(I_SCK))
    else $error("data out changed outside serial clock low phase");
  AST_OE_EDGE: assert property ($changed(O_SDO_OE) |-> !$past(I_SCK))
    else $error("output enable changed outside serial clock low phase");
  AST_IRQ_MASK: assert property (I_WR && I_ADDR == ADDR_IRQ_MASK && I_WDATA[IRQ_W-1:0] == RST_IRQ |-> ##2 !O_IRQ)
    else $error("interrupt high with all sources masked");
  AST_BCLK: assert property ($changed(O_BCLK) && n_tog == 2'h2 |-> half_cnt == cfg_q)
    else $error("bit clock half period does not match divider");
endmodule

//--- css_top_tb_top.sv
/*
  Self-checking bench for css_top: register tasks, codec model frames, expected values.
  Assumes the checker is bound below and the codec model answers on the link pins.
*/
`timescale 1ns/1ps
module css_top_tb_top
  import css_pkg::*;
;
  logic              clk;
  logic              srst;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata;
  logic              wr;
  logic              rd;
  logic [DATA_W-1:0] rdata;
  logic              sck;
  logic              fs;
  logic              sdi;
  logic              sdo;
  logic              sdo_oe;
  logic              bclk;
  logic              irq;
  int                n_mismatch;
  int                num_checks;
  logic [ADDR_W-1:0] idx_list [8] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h7, 4'h8, 4'hF};

  css_top u_dut (.I_CLK(clk), .I_SRST(srst), .I_ADDR(addr), .I_WDATA(wdata), .I_WR(wr), .I_RD(rd),
    .O_RDATA(rdata), .I_SCK(sck), .I_FS(fs), .I_SDI(sdi), .O_SDO(sdo), .O_SDO_OE(sdo_oe),
    .O_BCLK(bclk), .O_IRQ(irq));
  css_codec_model u_codec (.o_sck(sck), .o_fs(fs), .o_sdi(sdi), .i_sdo(sdo), .i_sdo_oe(sdo_oe));

  // 40 MHz module clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic report_and_stop();
    $display("mismatches=%0d checks=%0d", n_mismatch, num_checks);
    if (n_mismatch == 0 && num_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic chk_word(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One-cycle write strobe; back to back with the next access
  task automatic reg_wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    #1;
  endtask

  // Read data stands only in the cycle after the strobe
  task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp, input logic [DATA_W-1:0] m);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk_word(rdata & m, exp);
  endtask

  // Module clocks in one bit clock half period; the first wait aligns, a stuck clock uses up the bound
  task automatic chk_bclk(input int exp);
    int   n;
    logic b;
    n = 0;
    repeat (2) begin
      b = bclk;
      n = 0;
      while (bclk === b && n < 64) begin
        @(posedge clk);
        #1 n++;
      end
    end
    chk_word(DATA_W'(n), DATA_W'(exp));
  endtask

  // Frame on the link, then time for the synchronisers and word store
  task automatic frame(input int n, input logic [DATA_W-1:0] base);
    u_codec.run_frame(n, base);
    repeat (8) @(posedge clk);
    #1;
  endtask

  // Hang guard
  initial begin
    #1000000;
    n_mismatch++;
    report_and_stop();
  end

  initial begin
    srst = 1'b1;
    addr = '0;
    wdata = '0;
    wr = 1'b0;
    rd = 1'b0;
    n_mismatch = 0;
    num_checks = 0;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    foreach (idx_list[k]) rd_chk(idx_list[k], 16'h0000, 16'hFFFF);
    reg_wr(ADDR_CLKCFG, 16'hFFFF);
    rd_chk(ADDR_CLKCFG, 16'h0FFF, 16'hFFFF);
    reg_wr(ADDR_STATUS, 16'hFFFF);
    rd_chk(ADDR_STATUS, 16'h0000, 16'hFFFF);
    reg_wr(ADDR_CLKCFG, 16'h0004);
    chk_bclk(5);
    reg_wr(ADDR_IRQ_MASK, 16'h0005);
    // Two-word frame, only slot 1 received
    reg_wr(ADDR_CTRL, 16'h0041);
    reg_wr(ADDR_RXEN, 16'h0002);
    frame(2, 16'h1230);
    chk_bit(irq, 1'b1);
    chk_bit(u_codec.oe_last, 1'b0);
    rd_chk(ADDR_STATUS, 16'h0004, 16'h0F0E);
    rd_chk(ADDR_RXDATA, 16'h1231, 16'hFFFF);
    rd_chk(ADDR_STATUS, 16'h0000, 16'h0004);
    reg_wr(ADDR_IRQ_STAT, 16'h0001);
    rd_chk(ADDR_IRQ_STAT, 16'h0000, 16'h0001);
    chk_bit(irq, 1'b0);
    // Second word while full is dropped
    frame(2, 16'h5550);
    frame(2, 16'h6660);
    rd_chk(ADDR_STATUS, 16'h000C, 16'h000E);
    rd_chk(ADDR_STATUS, 16'h0004, 16'h000E);
    rd_chk(ADDR_RXDATA, 16'h5551, 16'hFFFF);
    reg_wr(ADDR_IRQ_STAT, 16'h000F);
    // Two-word block: full until both are read
    reg_wr(ADDR_CTRL, 16'h0051);
    reg_wr(ADDR_RXEN, 16'h0003);
    // Slot field read while the frame runs: slot 0 early, slot 1 in the second word
    fork
      frame(2, 16'h4000);
      begin
        repeat (60) @(posedge clk);
        #1 rd_chk(ADDR_STATUS, 16'h0000, 16'h0F00);
        repeat (140) @(posedge clk);
        #1 rd_chk(ADDR_STATUS, 16'h0100, 16'h0F00);
      end
    join
    rd_chk(ADDR_RXDATA, 16'h4000, 16'hFFFF);
    rd_chk(ADDR_STATUS, 16'h0004, 16'h0004);
    rd_chk(ADDR_RXDATA, 16'h4001, 16'hFFFF);
    rd_chk(ADDR_STATUS, 16'h0000, 16'h0004);
    // Transmit: drain the reset block, then load one word
    reg_wr(ADDR_CTRL, 16'h0000);
    reg_wr(ADDR_RXEN, 16'h0000);
    reg_wr(ADDR_TXEN, 16'h0001);
    frame(1, 16'h0000);
    rd_chk(ADDR_STATUS, 16'h0001, 16'h0003);
    reg_wr(ADDR_TXDATA, 16'h3C5A);
    rd_chk(ADDR_STATUS, 16'h0000, 16'h0001);
    frame(1, 16'h0000);
    chk_word(u_codec.rx_word, 16'h3C5A);
    chk_bit(u_codec.oe_last, 1'b1);
    rd_chk(ADDR_STATUS, 16'h0001, 16'h0003);
    // Underflow sends zeros, then the last word in resend mode
    frame(1, 16'h0000);
    chk_word(u_codec.rx_word, 16'h0000);
    rd_chk(ADDR_STATUS, 16'h0002, 16'h0002);
    reg_wr(ADDR_CTRL, 16'h0080);
    frame(1, 16'h0000);
    chk_word(u_codec.rx_word, 16'h3C5A);
    // Disabled slot: driven zeros, then floating
    reg_wr(ADDR_TXEN, 16'h0000);
    reg_wr(ADDR_CTRL, 16'h0000);
    frame(1, 16'h0000);
    chk_bit(u_codec.oe_last, 1'b1);
    chk_word(u_codec.rx_word, 16'h0000);
    reg_wr(ADDR_CTRL, 16'h0040);
    frame(1, 16'h0000);
    chk_bit(u_codec.oe_last, 1'b0);
    reg_wr(ADDR_IRQ_MASK, 16'h0000);
    repeat (3) @(posedge clk);
    #1 chk_bit(irq, 1'b0);
    report_and_stop();
  end
endmodule

bind css_top css_top_checker #(.WORD_W(WORD_W), .SLOT_N(SLOT_N)) u_chk (.I_CLK(I_CLK), .I_SRST(I_SRST),
  .I_ADDR(I_ADDR), .I_WDATA(I_WDATA), .I_WR(I_WR), .I_RD(I_RD), .O_RDATA(O_RDATA), .I_SCK(I_SCK),
  .I_FS(I_FS), .I_SDI(I_SDI), .O_SDO(O_SDO), .O_SDO_OE(O_SDO_OE), .O_BCLK(O_BCLK), .O_IRQ(O_IRQ));
